// ---- core/pwr_seq_pkg.sv ----
package pwr_seq_pkg;

    // ----------------------------------------
    // Clock and time base
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 10000000;
    // Half-millisecond tick so 1.5 ms and 12.5 ms are whole ticks
    localparam int unsigned TICK_US = 500;
    localparam int unsigned TICK_CYC = (CLK_HZ / 1000000) * TICK_US;
    localparam logic [12:0] TICK_LAST = 13'(TICK_CYC - 1);

    // ----------------------------------------
    // Times in microseconds as printed (glitch time in nanoseconds), then in ticks (glitch time in cycles)
    // ----------------------------------------
    localparam int unsigned STEP_1P5_US = 1500;
    localparam int unsigned STEP_12P5_US = 12500;
    localparam int unsigned STEP_25_US = 25000;
    localparam int unsigned STEP_50_US = 50000;
    localparam int unsigned RST_25_US = 25000;
    localparam int unsigned RST_50_US = 50000;
    localparam int unsigned RST_100_US = 100000;
    localparam int unsigned RST_200_US = 200000;
    localparam int unsigned WIN_50_US = 50000;
    localparam int unsigned WIN_100_US = 100000;
    localparam int unsigned WIN_200_US = 200000;
    localparam int unsigned DB_25_US = 25000;
    localparam int unsigned DB_100_US = 100000;
    localparam int unsigned DB_400_US = 400000;
    localparam int unsigned HOLDOFF_US = 3000;
    localparam int unsigned GLITCH_NS = 3000;

    localparam logic [10:0] STEP_1P5_T = 11'(STEP_1P5_US / TICK_US);
    localparam logic [10:0] STEP_12P5_T = 11'(STEP_12P5_US / TICK_US);
    localparam logic [10:0] STEP_25_T = 11'(STEP_25_US / TICK_US);
    localparam logic [10:0] STEP_50_T = 11'(STEP_50_US / TICK_US);
    localparam logic [10:0] RST_25_T = 11'(RST_25_US / TICK_US);
    localparam logic [10:0] RST_50_T = 11'(RST_50_US / TICK_US);
    localparam logic [10:0] RST_100_T = 11'(RST_100_US / TICK_US);
    localparam logic [10:0] RST_200_T = 11'(RST_200_US / TICK_US);
    localparam logic [10:0] WIN_50_T = 11'(WIN_50_US / TICK_US);
    localparam logic [10:0] WIN_100_T = 11'(WIN_100_US / TICK_US);
    localparam logic [10:0] WIN_200_T = 11'(WIN_200_US / TICK_US);
    localparam logic [10:0] DB_25_T = 11'(DB_25_US / TICK_US);
    localparam logic [10:0] DB_100_T = 11'(DB_100_US / TICK_US);
    localparam logic [10:0] DB_400_T = 11'(DB_400_US / TICK_US);
    localparam logic [10:0] HOLDOFF_T = 11'(HOLDOFF_US / TICK_US);
    // Least time, rounded up to whole cycles
    localparam logic [5:0] GLITCH_CYC = 6'((GLITCH_NS * (CLK_HZ / 1000000) + 999) / 1000);

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    localparam int unsigned NCH = 6;
    localparam int unsigned NPOS = 8;
    localparam logic [2:0] POS_LAST = 3'(NPOS - 1);
    localparam logic [2:0] POS_FIRST = 3'h0;
    localparam logic [10:0] CNT_ZERO = 11'h000;

    typedef enum logic [2:0] {
        SEQ_OFF = 3'b000,
        SEQ_UP = 3'b001,
        SEQ_RST_HOLD = 3'b010,
        SEQ_ON = 3'b011,
        SEQ_DOWN = 3'b100
    } seq_state_t;

    // Configuration carried as one bundle
    typedef struct packed {
        logic [1:0] up_delay_sel;
        logic [1:0] down_delay_sel;
        logic [1:0] reset_hold_sel;
        logic [1:0] abort_window_sel;
        logic [1:0] debounce_sel;
        logic request_pin_en;
        logic request_edge_mode;
    } seq_cfg_t;

endpackage : pwr_seq_pkg

// ---- core/power_sequence_timing_supervisor.sv ----
`timescale 1ns/1ps
// What this block does
// - Separate selectable up and down step delays
// - Hold reset output low after last supply
// - Undervoltage window expiry forces shutdown; off allowed
// - Debounce request pin with selectable period
// - Supply-fail output holds 3 ms after clear
// - Battery-fault output holds 3 ms after clear
// - Converter fault must persist 3 us
// - Request pin level or edge triggered
module power_sequence_timing_supervisor
    import pwr_seq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Configuration and software control
    input wire seq_cfg_t cfg,
    input wire logic [2:0] channel_position [NCH],
    input wire logic sw_power_on,
    input wire logic sw_power_off,
    // Pins and comparators (asynchronous)
    input wire logic power_request_pin,
    input wire logic [NCH-1:0] channel_above_uv,
    input wire logic [NCH-1:0] converter_fault,
    input wire logic supply_fail_latched,
    input wire logic battery_fault_raw,
    // Outputs
    output logic [NCH-1:0] channel_enable,
    output logic system_reset_release_out,
    output logic forced_shutdown,
    output logic supply_fail_out,
    output logic battery_fault_out,
    output logic fault_shutdown,
    output logic power_request_input
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [10:0] step_ticks(input logic [1:0] sel);
        case (sel)
            2'h0: step_ticks = STEP_1P5_T;
            2'h1: step_ticks = STEP_12P5_T;
            2'h2: step_ticks = STEP_25_T;
            default: step_ticks = STEP_50_T;
        endcase
    endfunction : step_ticks

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [NCH+3:0] sync1_r, sync2_r;
    always_ff @(posedge sys_clk)
    begin
        sync1_r <= {power_request_pin, supply_fail_latched, battery_fault_raw, channel_above_uv, 1'b0};
        sync2_r <= sync1_r;
    end
    wire req_s = sync2_r[NCH+3];
    wire pf_s = sync2_r[NCH+2];
    wire bf_s = sync2_r[NCH+1];
    wire [NCH-1:0] uv_ok_s = sync2_r[NCH:1];

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    logic [12:0] tick_cnt_r;
    wire tick = (tick_cnt_r == TICK_LAST);
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n) tick_cnt_r <= 13'h0000;
        else tick_cnt_r <= tick ? 13'h0000 : tick_cnt_r + 13'h0001;
    end

    // ----------------------------------------
    // Request pin debounce and trigger
    // ----------------------------------------
    logic req_deb_r, req_deb_d_r;
    logic [10:0] db_cnt_r;
    wire [10:0] db_len = (cfg.debounce_sel == 2'h1) ? DB_25_T :
                         (cfg.debounce_sel == 2'h2) ? DB_100_T : DB_400_T;
    wire db_bypass = (cfg.debounce_sel == 2'h0);
    // debounce, 0 setting bypasses; restarts on each change
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            req_deb_r <= 1'b1;
            db_cnt_r <= CNT_ZERO;
        end
        else if (req_s == req_deb_r) db_cnt_r <= CNT_ZERO;
        else if (db_bypass || (tick && db_cnt_r + 11'h001 >= db_len))
        begin
            req_deb_r <= req_s;
            db_cnt_r <= CNT_ZERO;
        end
        else if (tick) db_cnt_r <= db_cnt_r + 11'h001;
    end
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n) req_deb_d_r <= 1'b1;
        else req_deb_d_r <= req_deb_r;
    end
    // Active-low push-button press: falling edge of debounced level
    wire press = req_deb_d_r && !req_deb_r;
    // level mode follows low level, edge mode toggles on press
    // a press only counts once held past the debounce time
    wire level_on = cfg.request_pin_en && !cfg.request_edge_mode && !req_deb_r;
    wire level_off = cfg.request_pin_en && !cfg.request_edge_mode && req_deb_r;
    wire edge_hit = cfg.request_pin_en && cfg.request_edge_mode && press;

    // ----------------------------------------
    // Converter fault glitch filter
    // ----------------------------------------
    logic [5:0] gf_cnt_r;
    logic fault_r;
    // fault must persist before action; short pulses reset count
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !(|converter_fault)) gf_cnt_r <= 6'h00;
        else if (gf_cnt_r != GLITCH_CYC) gf_cnt_r <= gf_cnt_r + 6'h01;
    end
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n) fault_r <= 1'b0;
        else fault_r <= (gf_cnt_r == GLITCH_CYC);
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    seq_state_t state_r, state_nxt;
    logic [2:0] pos_r;
    logic [10:0] seq_cnt_r, win_cnt_r;
    logic abort_r;
    logic [NCH-1:0] en_r;

    wire want_on = sw_power_on || level_on || (edge_hit && state_r == SEQ_OFF);
    wire want_off = sw_power_off || level_off || abort_r || fault_r
                    || (edge_hit && state_r == SEQ_ON);
    wire [10:0] up_len = step_ticks(cfg.up_delay_sel);
    wire [10:0] dn_len = step_ticks(cfg.down_delay_sel);
    wire [10:0] rst_len = (cfg.reset_hold_sel == 2'h0) ? RST_25_T :
                          (cfg.reset_hold_sel == 2'h1) ? RST_50_T :
                          (cfg.reset_hold_sel == 2'h2) ? RST_100_T : RST_200_T;
    wire cnt_done_up = tick && (seq_cnt_r + 11'h001 >= up_len);
    wire cnt_done_dn = tick && (seq_cnt_r + 11'h001 >= dn_len);
    wire cnt_done_rst = tick && (seq_cnt_r + 11'h001 >= rst_len);

    // Next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            SEQ_OFF: if (want_on && !want_off) state_nxt = SEQ_UP;
            SEQ_UP: if (want_off) state_nxt = SEQ_DOWN;
                    else if (cnt_done_up && pos_r == POS_LAST) state_nxt = SEQ_RST_HOLD;
            SEQ_RST_HOLD: if (want_off) state_nxt = SEQ_DOWN;
                          else if (cnt_done_rst) state_nxt = SEQ_ON;
            SEQ_ON: if (want_off) state_nxt = SEQ_DOWN;
            SEQ_DOWN: if (cnt_done_dn && pos_r == POS_FIRST) state_nxt = SEQ_OFF;
            default: state_nxt = SEQ_OFF;
        endcase
    end

    // step positions with up/down delays; reset hold count
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_r <= SEQ_OFF;
            pos_r <= POS_FIRST;
            seq_cnt_r <= CNT_ZERO;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_nxt != state_r)
            begin
                seq_cnt_r <= CNT_ZERO;
                pos_r <= (state_nxt == SEQ_DOWN) ? POS_LAST : POS_FIRST;
            end
            else if ((state_r == SEQ_UP && cnt_done_up) || (state_r == SEQ_DOWN && cnt_done_dn))
            begin
                seq_cnt_r <= CNT_ZERO;
                pos_r <= (state_r == SEQ_UP) ? pos_r + 3'h1 : pos_r - 3'h1;
            end
            else if (tick) seq_cnt_r <= seq_cnt_r + 11'h001;
        end
    end

    // Enables: up turns on positions reached, down drops positions reached
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n) en_r <= '0;
        else
            for (int i = 0; i < NCH; i++)
            begin
                if (state_r == SEQ_UP && channel_position[i] == pos_r) en_r[i] <= 1'b1;
                else if (state_r == SEQ_DOWN && channel_position[i] == pos_r) en_r[i] <= 1'b0;
                else if (state_r == SEQ_OFF) en_r[i] <= 1'b0;
            end
    end

    // ----------------------------------------
    // Undervoltage window
    // ----------------------------------------
    wire [10:0] win_len = (cfg.abort_window_sel == 2'h1) ? WIN_50_T :
                          (cfg.abort_window_sel == 2'h2) ? WIN_100_T : WIN_200_T;
    wire win_off = (cfg.abort_window_sel == 2'h0);
    wire [NCH-1:0] late = en_r & ~uv_ok_s;
    // window restarts on each new enable; expiry aborts
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || win_off || state_r == SEQ_DOWN || state_r == SEQ_OFF)
        begin
            win_cnt_r <= CNT_ZERO;
            abort_r <= 1'b0;
        end
        else if (!(|late) || (en_r != channel_enable)) win_cnt_r <= CNT_ZERO;
        else if (tick)
        begin
            win_cnt_r <= win_cnt_r + 11'h001;
            if (win_cnt_r + 11'h001 >= win_len) abort_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // Supply-fail and battery-fault holdoffs
    // ----------------------------------------
    logic [10:0] pf_cnt_r, bf_cnt_r;
    logic pf_out_r, bf_out_r;
    // supply-fail stays asserted 3 ms after latch clears
    // A fresh latch wins over the count and restarts it
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || pf_s) pf_cnt_r <= CNT_ZERO;
        else if (pf_out_r && tick) pf_cnt_r <= pf_cnt_r + 11'h001;
        if (!rst_n) pf_out_r <= 1'b0;
        else if (pf_s) pf_out_r <= 1'b1;
        else if (pf_out_r && tick && pf_cnt_r + 11'h001 >= HOLDOFF_T) pf_out_r <= 1'b0;
    end
    // battery-fault (active low) released 3 ms after clear
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || bf_s) bf_cnt_r <= CNT_ZERO;
        else if (bf_out_r && tick) bf_cnt_r <= bf_cnt_r + 11'h001;
        if (!rst_n) bf_out_r <= 1'b0;
        else if (bf_s) bf_out_r <= 1'b1;
        else if (bf_out_r && tick && bf_cnt_r + 11'h001 >= HOLDOFF_T) bf_out_r <= 1'b0;
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            channel_enable <= '0;
            system_reset_release_out <= 1'b0;
            forced_shutdown <= 1'b0;
            supply_fail_out <= 1'b0;
            battery_fault_out <= 1'b1;
            fault_shutdown <= 1'b0;
            power_request_input <= 1'b1;
        end
        else
        begin
            channel_enable <= en_r;
            system_reset_release_out <= (state_r == SEQ_ON);
            forced_shutdown <= abort_r;
            supply_fail_out <= pf_out_r;
            battery_fault_out <= !bf_out_r;
            fault_shutdown <= fault_r;
            power_request_input <= req_deb_r;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_glitch;
        @(posedge sys_clk) disable iff (!rst_n) $rose(fault_r) |-> $past(|converter_fault, 2);
    endproperty
    a_glitch: assert property (p_glitch) else $error("fault accepted too early");
    property p_reset_hold;
        @(posedge sys_clk) disable iff (!rst_n) $rose(state_r == SEQ_ON) |-> $past(state_r) == SEQ_RST_HOLD;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset released without hold");
    property p_rst_out;
        @(posedge sys_clk) disable iff (!rst_n) system_reset_release_out |-> $past(state_r) == SEQ_ON;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("reset output high outside on");
    property p_abort;
        @(posedge sys_clk) disable iff (!rst_n) abort_r && state_r != SEQ_OFF |=> state_r == SEQ_DOWN;
    endproperty
    a_abort: assert property (p_abort) else $error("window expiry did not shut down");
    property p_win_off;
        @(posedge sys_clk) disable iff (!rst_n) win_off |=> !abort_r;
    endproperty
    a_win_off: assert property (p_win_off) else $error("abort with window off");
    property p_pf;
        @(posedge sys_clk) disable iff (!rst_n) pf_s |=> pf_out_r [*8];
    endproperty
    a_pf: assert property (p_pf) else $error("supply fail dropped early");
    property p_bf;
        @(posedge sys_clk) disable iff (!rst_n) bf_s |=> ##1 !battery_fault_out [*3];
    endproperty
    a_bf: assert property (p_bf) else $error("battery fault released early");
    property p_step;
        @(posedge sys_clk) disable iff (!rst_n)
            state_r == SEQ_UP && $changed(pos_r) |-> $past(seq_cnt_r) + 11'h001 >= $past(up_len);
    endproperty
    a_step: assert property (p_step) else $error("step before delay");
    property p_deb;
        @(posedge sys_clk) disable iff (!rst_n) $changed(req_deb_r) |-> db_bypass || $past(tick);
    endproperty
    a_deb: assert property (p_deb) else $error("debounce bypassed");

endmodule : power_sequence_timing_supervisor

// ---- testbench/reg_channel_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Regulator channels and host request pin
// ----------------------------------------
module reg_channel_model
    import pwr_seq_pkg::*;
#(
    parameter int unsigned RISE_CYC = 20
)
(
    // Clock
    input wire logic sys_clk,
    // Enables from the supervisor, button press from the bench
    input wire logic [NCH-1:0] channel_enable,
    input wire logic press,
    // Comparator outputs and the request pin
    output logic [NCH-1:0] channel_above_uv,
    output logic power_request_pin
);
    int unsigned age [NCH];

    // Start below threshold so nothing looks powered before the first edge
    initial
    begin
        channel_above_uv = '0;
        for (int i = 0; i < NCH; i++)
            age[i] = 0;
    end

    // Output climbs past UV a while after enable, drops at once when disabled
    always @(posedge sys_clk)
    begin
        for (int i = 0; i < NCH; i++)
        begin
            age[i] <= (channel_enable[i] === 1'b1) ? age[i] + 1 : 0;
            channel_above_uv[i] <= (channel_enable[i] === 1'b1) && (age[i] >= RISE_CYC);
        end
    end

    // pin held low
    // The pin stays low for as long as the bench holds the press
    assign power_request_pin = ~press;
endmodule : reg_channel_model

// ---- testbench/power_sequence_timing_supervisor_bench.sv ----
`timescale 1ns/1ps
module power_sequence_timing_supervisor_bench;
    import pwr_seq_pkg::*;
    // Whole run is roughly 60k cycles, about half of it the holdoff wait
    localparam int unsigned LIMIT = 80000;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    seq_cfg_t cfg;
    logic [2:0] channel_position [NCH];
    logic sw_power_on = 1'b0;
    logic sw_power_off = 1'b0;
    logic press = 1'b0;
    logic power_request_pin;
    logic [NCH-1:0] channel_above_uv;
    logic [NCH-1:0] converter_fault = '0;
    logic supply_fail_latched = 1'b0;
    logic battery_fault_raw = 1'b0;
    logic [NCH-1:0] channel_enable;
    logic system_reset_release_out;
    logic forced_shutdown;
    logic supply_fail_out;
    logic battery_fault_out;
    logic fault_shutdown;
    logic power_request_input;
    int unsigned errors = 0;
    int unsigned n_tests = 0;
    int unsigned cyc = 0;
    logic [31:0] seed = 32'h00006357;

    // ----------------------------------------
    // Design and far side
    // ----------------------------------------
    power_sequence_timing_supervisor power_sequence_timing_supervisor_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg), .channel_position(channel_position),
        .sw_power_on(sw_power_on), .sw_power_off(sw_power_off), .power_request_pin(power_request_pin),
        .channel_above_uv(channel_above_uv), .converter_fault(converter_fault),
        .supply_fail_latched(supply_fail_latched), .battery_fault_raw(battery_fault_raw),
        .channel_enable(channel_enable), .system_reset_release_out(system_reset_release_out),
        .forced_shutdown(forced_shutdown), .supply_fail_out(supply_fail_out),
        .battery_fault_out(battery_fault_out), .fault_shutdown(fault_shutdown),
        .power_request_input(power_request_input)
    );
    reg_channel_model reg_channel_model_inst (
        .sys_clk(sys_clk), .channel_enable(channel_enable), .press(press),
        .channel_above_uv(channel_above_uv), .power_request_pin(power_request_pin)
    );

    // ----------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------
    always #50 sys_clk = ~sys_clk;

    // A hang counts as a mismatch and still reaches the verdict
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            errors++;
            report_and_stop();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    // Whole ticks only; the first tick of a count may be partial
    function automatic int unsigned ticks_cyc(input int unsigned us);
        return us / TICK_US * TICK_CYC;
    endfunction : ticks_cyc

    function automatic int unsigned step_us(input logic [1:0] sel);
        case (sel)
            2'h0: return STEP_1P5_US;
            2'h1: return STEP_12P5_US;
            2'h2: return STEP_25_US;
            default: return STEP_50_US;
        endcase
    endfunction : step_us

    // Inputs always move a fixed 10 ns after the rising edge
    task automatic step(input int unsigned n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask : step

    task automatic chk(input bit ok, input string msg);
        n_tests++;
        if (!ok)
        begin
            errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        int unsigned w;
        int unsigned len;
        int unsigned d;
        cfg = '{up_delay_sel: 2'h0, down_delay_sel: 2'h0, reset_hold_sel: 2'h0, abort_window_sel: 2'h1,
                debounce_sel: 2'h0, request_pin_en: 1'b1, request_edge_mode: 1'b0};
        for (int i = 0; i < NCH; i++)
            channel_position[i] = 3'(i);
        step(4);
        chk(channel_enable === 6'h00 && system_reset_release_out === 1'b0 && battery_fault_out === 1'b1
            && power_request_input === 1'b1 && supply_fail_out === 1'b0 && fault_shutdown === 1'b0
            && forced_shutdown === 1'b0, "reset values");
        rst_n = 1'b1;
        step(2);
        $display("test reset done");

        // glitch filter
        // Random short pulses on random channels must never act
        for (int k = 0; k < 4; k++)
        begin
            seed = xs(seed);
            len = 1 + (seed % (GLITCH_CYC - 6'h04));
            d = seed[15:8] % NCH;
            converter_fault[d] = 1'b1;
            for (w = 0; w < len + 8; w++)
            begin
                if (w == len)
                    converter_fault = '0;
                step(1);
                chk(fault_shutdown === 1'b0, "short fault pulse acted");
            end
        end
        converter_fault[d] = 1'b1;
        step(GLITCH_CYC - 3);
        chk(fault_shutdown === 1'b0, "fault acted before filter time");
        step(8);
        chk(fault_shutdown === 1'b1, "persistent fault ignored");
        converter_fault = '0;
        step(5);
        $display("test glitch done");

        // edge mode, then a reset in mid-run
        // A short press starts power-up, which carries on after release
        cfg.request_edge_mode = 1'b1;
        press = 1'b1;
        step(4);
        press = 1'b0;
        for (w = 0; w < 8 && channel_enable[0] !== 1'b1; w++)
            step(1);
        step(4);
        chk(channel_enable === 6'h01, "edge press did not latch power-up");
        rst_n = 1'b0;
        step(4);
        chk(channel_enable === 6'h00 && system_reset_release_out === 1'b0, "mid-run reset ignored");
        rst_n = 1'b1;
        cfg.request_edge_mode = 1'b0;
        step(2);
        $display("test edge mode done");

        // holdoff after clear
        // Both indications run together to save run time
        supply_fail_latched = 1'b1;
        battery_fault_raw = 1'b1;
        step(6);
        chk(supply_fail_out === 1'b1 && battery_fault_out === 1'b0, "indications not raised");
        supply_fail_latched = 1'b0;
        battery_fault_raw = 1'b0;
        step(ticks_cyc(HOLDOFF_US) - TICK_CYC - 10);
        chk(supply_fail_out === 1'b1 && battery_fault_out === 1'b0, "indication released early");
        for (w = 0; w < TICK_CYC + 20 && !(supply_fail_out === 1'b0 && battery_fault_out === 1'b1); w++)
            step(1);
        chk(supply_fail_out === 1'b0 && battery_fault_out === 1'b1, "indication never released");
        $display("test holdoff done");

        // pin start, step delay
        // Level-triggered pin without debounce starts power-up at once
        press = 1'b1;
        for (w = 0; w < 8 && power_request_input !== 1'b0; w++)
            step(1);
        chk(power_request_input === 1'b0, "request pin not followed");
        for (w = 0; w < 8 && channel_enable[0] !== 1'b1; w++)
            step(1);
        chk(channel_enable === 6'h01, "first position not enabled");
        step(ticks_cyc(step_us(cfg.up_delay_sel)) - TICK_CYC - 20);
        chk(channel_enable === 6'h01, "second position early");
        for (w = 0; w < TICK_CYC + 40 && channel_enable[1] !== 1'b1; w++)
            step(1);
        chk(channel_enable === 6'h03, "second position late");
        chk(forced_shutdown === 1'b0, "window abort with healthy supplies");
        chk(system_reset_release_out === 1'b0, "reset released mid sequence");
        $display("test power up done");

        // reverse order on the way down
        // Abort mid power-up; live channels moved to the top positions
        // so the down walk reaches them without a long run
        press = 1'b0;
        sw_power_off = 1'b1;
        channel_position[0] = 3'h6;
        channel_position[1] = 3'h7;
        for (w = 0; w < 8 && channel_enable[1] !== 1'b0; w++)
            step(1);
        chk(channel_enable === 6'h01, "down order wrong");
        for (w = 0; w < 4 * TICK_CYC && channel_enable[0] !== 1'b0; w++)
            step(1);
        d = ticks_cyc(step_us(cfg.down_delay_sel)) - TICK_CYC - 20;
        chk(w >= d && channel_enable === 6'h00, "down step delay wrong");
        $display("test power down done");
        report_and_stop();
    end
endmodule : power_sequence_timing_supervisor_bench
